// >>> design/thpm_pkg.sv
// Shared constants and types for the T1 health and performance monitor
package thpm_pkg;
  localparam int NPORT        = 4;
  localparam int NSET         = 2 + 2 * NPORT;
  localparam int NCNT         = 5;
  localparam int SET_USER     = 1;
  localparam int SET_PORT0    = 2;
  localparam int CNT_STAT_EVT = 4;
  localparam int AGG_DEPTH    = 96;
  localparam int PORT_DEPTH   = 32;
  localparam int HIST_W       = 7;
  localparam int CNT_W        = 16;
  localparam int TOT_W        = 24;
  localparam int NMGMT        = 3;
  localparam int MGMT_AUX     = 2;
  localparam int RATE_W       = 8;
  localparam int CODE_W       = 32;
  localparam int STEST_W      = 16;
  localparam int LOOP_W       = 4;
  localparam int TIMER_W      = 10;
  localparam logic [TIMER_W-1:0] IVL_SECS = 10'h384;
  localparam int CLK_HZ       = 250_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES  = TICK_PERIOD_S * CLK_HZ;
  localparam int TICK_W       = 28;
  // Register byte offsets
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_THRESH    = 8'h04;
  localparam logic [7:0] A_STATUS    = 8'h08;
  localparam logic [7:0] A_FAULT     = 8'h0c;
  localparam logic [7:0] A_SELFTEST  = 8'h10;
  localparam logic [7:0] A_IRQ_STAT  = 8'h14;
  localparam logic [7:0] A_IRQ_MASK  = 8'h18;
  localparam logic [7:0] A_PERF_SEL  = 8'h1c;
  localparam logic [7:0] A_PERF_DATA = 8'h20;
  // Control fields
  localparam int C_ESF      = 0;
  localparam int C_CLR_USER = 1;
  localparam int C_INT_CLK  = 2;
  localparam int C_LINK_LSB = 4;
  localparam int C_MGMT_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0700;
  // Performance select fields
  localparam int PS_SET_LSB = 0;
  localparam int PS_ENT_LSB = 8;
  localparam int PS_FLD_LSB = 16;
  localparam int PS_TOT     = 19;
  localparam logic [2:0] F_TIMER = 3'h5;
  localparam logic [2:0] F_VALID = 3'h6;
  // Interrupt bits
  localparam int IRQ_W     = 5;
  localparam int IRQ_IVL   = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_DL    = 2;
  localparam int IRQ_MCLK  = 3;
  localparam int IRQ_STEST = 4;

  typedef struct packed {
    logic sev;
    logic bes;
    logic ses;
    logic uas;
    logic es;
  } thpm_sec_t;

  typedef struct packed {
    logic              timing_int;
    logic              operational;
    logic              mclk_fail;
    logic              test_active;
    logic              download_failed;
    logic              internal_fault;
    logic              selftest_fail;
    logic [NMGMT-1:0]  mgmt_down;
    logic [NPORT-1:0]  excessive_error_rate;
    logic [NPORT-1:0]  oof;
  } thpm_alarm_t;
endpackage

// >>> design/thpm_top.sv
// Health, alarm and interval performance monitor with Wishbone registers
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
module thpm_top #(
  parameter int unsigned TICK_CYCLES = thpm_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                                          clk_i,
  input  wire logic                                          rst_i,
  // Wishbone slave
  input  wire logic                                          wb_cyc_i,
  input  wire logic                                          wb_stb_i,
  input  wire logic                                          wb_we_i,
  input  wire logic [7:0]                                    wb_adr_i,
  input  wire logic [3:0]                                    wb_sel_i,
  input  wire logic [31:0]                                   wb_dat_i,
  output logic      [31:0]                                   wb_dat_o,
  output logic                                               wb_ack_o,
  // Line and port conditions
  input  wire logic [thpm_pkg::NPORT-1:0]                    port_oof_i,
  input  wire logic [thpm_pkg::NPORT-1:0][thpm_pkg::RATE_W-1:0] port_err_rate_i,
  input  wire logic [thpm_pkg::NMGMT-1:0]                    mgmt_link_down_i,
  input  wire thpm_pkg::thpm_sec_t [thpm_pkg::NSET-1:0]      sec_flags_i,
  // Device health events
  input  wire logic                                          selftest_done_i,
  input  wire logic [thpm_pkg::STEST_W-1:0]                  selftest_result_i,
  input  wire logic                                          fault_evt_i,
  input  wire logic [thpm_pkg::CODE_W-1:0]                   internal_fault_code_i,
  input  wire logic                                          download_abort_i,
  input  wire logic [thpm_pkg::LOOP_W-1:0]                   loop_active_i,
  input  wire logic                                          pattern_active_i,
  input  wire logic                                          mclk_lost_i,
  // Status outputs
  output thpm_pkg::thpm_alarm_t                              alarm_o,
  output logic                                               irq_o
);
  import thpm_pkg::*;

  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = nw[8*b +: 8];
    end
    return r;
  endfunction

  function automatic int depth_of(input int s);
    return (s < SET_PORT0) ? AGG_DEPTH : PORT_DEPTH;
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v, input logic f);
    return (f && v != '1) ? v + 1'b1 : v;
  endfunction

  function automatic logic [HIST_W-1:0] hist_idx(input logic [HIST_W-1:0] wp, input int ago, input int d);
    int t;
    t = (int'(wp) + d - ago) % d;
    return HIST_W'(t);
  endfunction

  logic [31:0]              ctrl_reg;
  logic [31:0]              thr_reg;
  logic [31:0]              psel_reg;
  logic [IRQ_W-1:0]         irq_stat_reg;
  logic [IRQ_W-1:0]         irq_mask_reg;
  logic                     clr_user_reg;
  logic                     ack_reg;
  logic [31:0]              dat_reg;
  logic [31:0]              rd_data;
  logic [31:0]              perf_rd;
  logic [TICK_W-1:0]        presc_reg;
  logic                     tick_reg;
  logic [TIMER_W-1:0]       timer_reg;
  logic                     ivl_end;
  logic [NPORT-1:0]         oof_reg;
  logic [NPORT-1:0]         err_alarm_reg;
  logic [NMGMT-1:0]         mgmt_down_reg;
  logic                     aux_pend_reg;
  logic                     stest_fail_reg;
  logic [STEST_W-1:0]       stest_code_reg;
  logic                     fault_reg;
  logic [CODE_W-1:0]        fault_code_reg;
  logic                     dl_fail_reg;
  logic                     test_reg;
  logic                     mclk_fail_reg;
  thpm_alarm_t              alarm_reg;
  logic                     irq_reg;
  logic [IRQ_W-1:0]         irq_evt;
  logic                     req;
  logic                     wr;
  logic [CNT_W-1:0]         cur_reg  [NSET][NCNT];
  logic [CNT_W-1:0]         hist_reg [NSET][AGG_DEPTH][NCNT];
  logic [TOT_W-1:0]         tot_reg  [NSET][NCNT];
  logic [HIST_W-1:0]        wp_reg   [NSET];
  logic [HIST_W-1:0]        valid_reg[NSET];
  logic [NSET-1:0]          set_on;

  assign req      = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr       = req && wb_we_i;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign alarm_o  = alarm_reg;
  assign irq_o    = irq_reg;
  assign ivl_end  = tick_reg && (timer_reg == IVL_SECS - 1'b1);

  // Which sets collect this second
  always_comb
  begin
    for (int s = 0; s < NSET; s++)
    begin
      if (s < SET_PORT0)
        set_on[s] = ctrl_reg[C_ESF];
      else
        set_on[s] = ctrl_reg[C_LINK_LSB + (s - SET_PORT0) / 2];
    end
  end

  // One-second tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i || presc_reg == TICK_W'(TICK_CYCLES - 1))
      presc_reg <= '0;
    else
      presc_reg <= presc_reg + 1'b1;
    tick_reg <= !rst_i && (presc_reg == TICK_W'(TICK_CYCLES - 1));
  end

  // Current-interval timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr_user_reg)
      timer_reg <= '0;
    else if (ivl_end)
      timer_reg <= '0;
    else if (tick_reg)
      timer_reg <= timer_reg + 1'b1;
  end

  // Interval counters, history and totals
  always_ff @(posedge clk_i)
  begin
    for (int s = 0; s < NSET; s++)
    begin
      if (rst_i || (clr_user_reg && s == SET_USER))
      begin
        wp_reg[s]    <= '0;
        valid_reg[s] <= '0;
        for (int c = 0; c < NCNT; c++)
        begin
          cur_reg[s][c] <= '0;
          tot_reg[s][c] <= '0;
        end
      end
      else if (tick_reg && set_on[s])
      begin
        for (int c = 0; c < NCNT; c++)
        begin
          if (c != CNT_STAT_EVT || s == SET_USER)
          begin
            if (ivl_end)
            begin
              hist_reg[s][wp_reg[s]][c] <= sat_inc(cur_reg[s][c], sec_flags_i[s][c]);
              tot_reg[s][c] <= tot_reg[s][c] + TOT_W'(sat_inc(cur_reg[s][c], sec_flags_i[s][c]))
                - ((int'(valid_reg[s]) == depth_of(s)) ? TOT_W'(hist_reg[s][wp_reg[s]][c]) : '0);
              cur_reg[s][c] <= '0;
            end
            else
              cur_reg[s][c] <= sat_inc(cur_reg[s][c], sec_flags_i[s][c]);
          end
          else if (ivl_end)
            hist_reg[s][wp_reg[s]][c] <= '0;
        end
        if (ivl_end)
        begin
          wp_reg[s] <= (int'(wp_reg[s]) == depth_of(s) - 1) ? '0 : wp_reg[s] + 1'b1;
          if (int'(valid_reg[s]) != depth_of(s))
            valid_reg[s] <= valid_reg[s] + 1'b1;
        end
      end
    end
  end

  // Port framing and error-rate alarms
  always_ff @(posedge clk_i)
  begin
    for (int p = 0; p < NPORT; p++)
    begin
      if (rst_i || !ctrl_reg[C_LINK_LSB + p])
      begin
        oof_reg[p]       <= 1'b0;
        err_alarm_reg[p] <= 1'b0;
      end
      else
      begin
        oof_reg[p] <= port_oof_i[p];
        if (port_err_rate_i[p] > thr_reg[RATE_W*p +: RATE_W])
          err_alarm_reg[p] <= 1'b1;
        else if (port_err_rate_i[p] < thr_reg[RATE_W*p +: RATE_W])
          err_alarm_reg[p] <= 1'b0;
      end
    end
  end

  // Management link state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mgmt_down_reg <= '0;
      aux_pend_reg  <= 1'b1;
    end
    else
    begin
      for (int m = 0; m < NMGMT; m++)
      begin
        if (m != MGMT_AUX)
          mgmt_down_reg[m] <= ctrl_reg[C_MGMT_LSB + m] && mgmt_link_down_i[m];
      end
      if (aux_pend_reg)
        mgmt_down_reg[MGMT_AUX] <= ctrl_reg[C_MGMT_LSB + MGMT_AUX] && mgmt_link_down_i[MGMT_AUX];
      aux_pend_reg <= 1'b0;
    end
  end

  // Latched health conditions
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stest_fail_reg <= 1'b0;
      stest_code_reg <= '0;
      fault_reg      <= 1'b0;
      fault_code_reg <= '0;
      dl_fail_reg    <= 1'b0;
    end
    else
    begin
      if (selftest_done_i)
      begin
        stest_fail_reg <= selftest_result_i != '0;
        stest_code_reg <= selftest_result_i;
      end
      if (fault_evt_i && !fault_reg)
      begin
        fault_reg      <= 1'b1;
        fault_code_reg <= internal_fault_code_i;
      end
      if (download_abort_i)
        dl_fail_reg <= 1'b1;
    end
  end

  // Test and clock conditions
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      test_reg      <= 1'b0;
      mclk_fail_reg <= 1'b0;
    end
    else
    begin
      test_reg      <= (|loop_active_i) || pattern_active_i;
      mclk_fail_reg <= mclk_lost_i;
    end
  end

  // Alarm summary
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      alarm_reg <= '0;
    else
    begin
      alarm_reg.oof                  <= oof_reg;
      alarm_reg.excessive_error_rate <= err_alarm_reg;
      alarm_reg.mgmt_down            <= mgmt_down_reg;
      alarm_reg.selftest_fail        <= stest_fail_reg;
      alarm_reg.internal_fault       <= fault_reg;
      alarm_reg.download_failed      <= dl_fail_reg;
      alarm_reg.test_active          <= test_reg;
      alarm_reg.mclk_fail            <= mclk_fail_reg;
      alarm_reg.timing_int           <= mclk_fail_reg || ctrl_reg[C_INT_CLK];
      alarm_reg.operational          <= !((|oof_reg) || (|err_alarm_reg) || (|mgmt_down_reg) || stest_fail_reg
        || fault_reg || dl_fail_reg || test_reg || mclk_fail_reg);
    end
  end

  // Interrupt status, mask and output
  always_comb
  begin
    irq_evt            = '0;
    irq_evt[IRQ_IVL]   = ivl_end;
    irq_evt[IRQ_FAULT] = fault_evt_i && !fault_reg;
    irq_evt[IRQ_DL]    = download_abort_i && !dl_fail_reg;
    irq_evt[IRQ_MCLK]  = mclk_lost_i && !mclk_fail_reg;
    irq_evt[IRQ_STEST] = selftest_done_i && selftest_result_i != '0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      if (wr && wb_adr_i == A_IRQ_STAT && wb_sel_i[0])
        irq_stat_reg <= (irq_stat_reg & ~wb_dat_i[IRQ_W-1:0]) | irq_evt;
      else
        irq_stat_reg <= irq_stat_reg | irq_evt;
      if (wr && wb_adr_i == A_IRQ_MASK && wb_sel_i[0])
        irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_reg     <= CTRL_RST;
      thr_reg      <= '0;
      psel_reg     <= '0;
      clr_user_reg <= 1'b0;
    end
    else
    begin
      clr_user_reg <= wr && wb_adr_i == A_CTRL && wb_sel_i[0] && wb_dat_i[C_CLR_USER];
      if (wr && wb_adr_i == A_CTRL)
      begin
        ctrl_reg             <= bmerge(ctrl_reg, wb_dat_i, wb_sel_i);
        ctrl_reg[C_CLR_USER] <= 1'b0;
      end
      if (wr && wb_adr_i == A_THRESH)
        thr_reg <= bmerge(thr_reg, wb_dat_i, wb_sel_i);
      if (wr && wb_adr_i == A_PERF_SEL)
        psel_reg <= bmerge(psel_reg, wb_dat_i, wb_sel_i);
    end
  end

  // Performance readout
  always_comb
  begin
    int s;
    int f;
    int e;
    s = int'(psel_reg[PS_SET_LSB +: 4]);
    f = int'(psel_reg[PS_FLD_LSB +: 3]);
    e = int'(psel_reg[PS_ENT_LSB +: HIST_W]);
    perf_rd = '0;
    if (s < NSET)
    begin
      if (psel_reg[PS_TOT] && f < NCNT)
        perf_rd = 32'(tot_reg[s][f]);
      else if (psel_reg[PS_FLD_LSB +: 3] == F_TIMER)
        perf_rd = 32'(timer_reg);
      else if (psel_reg[PS_FLD_LSB +: 3] == F_VALID)
        perf_rd = 32'(valid_reg[s]);
      else if (f < NCNT && e == 0)
        perf_rd = 32'(cur_reg[s][f]);
      else if (f < NCNT && e <= int'(valid_reg[s]))
        perf_rd = 32'(hist_reg[s][hist_idx(wp_reg[s], e, depth_of(s))][f]);
    end
  end

  // Read decode
  always_comb
  begin
    if (wb_adr_i == A_CTRL)
      rd_data = ctrl_reg;
    else if (wb_adr_i == A_THRESH)
      rd_data = thr_reg;
    else if (wb_adr_i == A_STATUS)
      rd_data = 32'(alarm_reg);
    else if (wb_adr_i == A_FAULT)
      rd_data = fault_code_reg;
    else if (wb_adr_i == A_SELFTEST)
      rd_data = 32'(stest_code_reg);
    else if (wb_adr_i == A_IRQ_STAT)
      rd_data = 32'(irq_stat_reg);
    else if (wb_adr_i == A_IRQ_MASK)
      rd_data = 32'(irq_mask_reg);
    else if (wb_adr_i == A_PERF_SEL)
      rd_data = psel_reg;
    else if (wb_adr_i == A_PERF_DATA)
      rd_data = perf_rd;
    else
      rd_data = '0;
  end

  // Wishbone answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end
    else
    begin
      ack_reg <= req;
      if (req && !wb_we_i)
        dat_reg <= rd_data;
    end
  end
endmodule

// >>> test/thpm_props.sv
// Port-level assertion checker for the health monitor
module thpm_props (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // Bus handshake
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_ack_o,
  // Conditions and status
  input  wire logic [thpm_pkg::NPORT-1:0]   port_oof_i,
  input  wire logic [thpm_pkg::LOOP_W-1:0]  loop_active_i,
  input  wire logic                         pattern_active_i,
  input  wire logic                         mclk_lost_i,
  input  wire thpm_pkg::thpm_alarm_t        alarm_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import thpm_pkg::*;
  logic [1:0] up_reg;
  logic       test_req;
  assign test_req = (|loop_active_i) | pattern_active_i;
  // Edges since reset release
  always_ff @(posedge clk_i)
    if (rst_i)
      up_reg <= 2'h0;
    else if (up_reg != 2'h3)
      up_reg <= up_reg + 2'h1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  a_oof_from_input: assert property (up_reg == 2'h3 |-> (alarm_o.oof & ~$past(port_oof_i, 2)) == '0)
    else $error("out-of-frame without cause");
  a_fault_stays_set: assert property (alarm_o.internal_fault |=> alarm_o.internal_fault)
    else $error("fault status dropped");
  a_download_stays_set: assert property (alarm_o.download_failed |=> $stable(alarm_o.download_failed))
    else $error("download status dropped");
  a_test_follows: assert property (up_reg == 2'h3 |-> alarm_o.test_active == $past(test_req, 2))
    else $error("test status wrong");
  a_mclk_follows: assert property (up_reg == 2'h3 |-> alarm_o.mclk_fail == $past(mclk_lost_i, 2))
    else $error("master clock status wrong");
  a_mclk_int_timing: assert property (alarm_o.mclk_fail |-> alarm_o.timing_int)
    else $error("timing not internal");
  a_oper_alone: assert property (alarm_o.operational |-> alarm_o[15:0] == 16'h0)
    else $error("operational with alarm");
endmodule
bind thpm_top thpm_props u_thpm_props (
  .clk_i            (clk_i),
  .rst_i            (rst_i),
  .wb_cyc_i         (wb_cyc_i),
  .wb_stb_i         (wb_stb_i),
  .wb_ack_o         (wb_ack_o),
  .port_oof_i       (port_oof_i),
  .loop_active_i    (loop_active_i),
  .pattern_active_i (pattern_active_i),
  .mclk_lost_i      (mclk_lost_i),
  .alarm_o          (alarm_o)
);

// >>> test/thpm_line_model.sv
// Line-side model giving per-second performance flags
module thpm_line_model (
  // Clock
  input  wire logic                                     clk_i,
  // Line errored or clean
  input  wire logic                                     line_on_i,
  // Flags per set
  output thpm_pkg::thpm_sec_t [thpm_pkg::NSET-1:0]      sec_flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import thpm_pkg::*;
  // Errored and status-event second on every set
  always_ff @(posedge clk_i)
    for (int s = 0; s < NSET; s++)
      sec_flags_o[s] <= line_on_i ? thpm_sec_t'(5'h11) : thpm_sec_t'(5'h00);
endmodule

// >>> test/thpm_top_tb.sv
// Self-checking bench for the health monitor
module thpm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import thpm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [NPORT-1:0] port_oof_i = '0;
  logic [NPORT-1:0][RATE_W-1:0] port_err_rate_i = '0;
  logic [NMGMT-1:0] mgmt_link_down_i = '0;
  thpm_sec_t [NSET-1:0] sec_flags;
  logic selftest_done_i = 1'b0, fault_evt_i = 1'b0, download_abort_i = 1'b0;
  logic [STEST_W-1:0] selftest_result_i = '0;
  logic [CODE_W-1:0] internal_fault_code_i = '0;
  logic [LOOP_W-1:0] loop_active_i = '0;
  logic pattern_active_i = 1'b0, mclk_lost_i = 1'b0, irq_o, line_on = 1'b0;
  thpm_alarm_t alarm_o;
  int fail_count = 0;
  int comparisons = 0;
  always #2 clk_i = ~clk_i;
  thpm_top #(.TICK_CYCLES(4)) u_thpm_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_oof_i(port_oof_i),
    .port_err_rate_i(port_err_rate_i), .mgmt_link_down_i(mgmt_link_down_i), .sec_flags_i(sec_flags),
    .selftest_done_i(selftest_done_i), .selftest_result_i(selftest_result_i), .fault_evt_i(fault_evt_i),
    .internal_fault_code_i(internal_fault_code_i), .download_abort_i(download_abort_i),
    .loop_active_i(loop_active_i), .pattern_active_i(pattern_active_i), .mclk_lost_i(mclk_lost_i),
    .alarm_o(alarm_o), .irq_o(irq_o));
  thpm_line_model u_thpm_line_model (.clk_i(clk_i), .line_on_i(line_on), .sec_flags_o(sec_flags));
  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Classic single Wishbone cycle
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n++ < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    check(32'(wb_ack_o), 32'h1, "bus ack");
  endtask
  task perf(input int s, input int e, input int f, input int t, input logic [31:0] exp, input string what);
    bus(1'b1, A_PERF_SEL, 32'(s) | (32'(e) << 8) | (32'(f) << 16) | (32'(t) << 19), rd);
    bus(1'b0, A_PERF_DATA, 32'h0, rd);
    check(rd, exp, what);
  endtask
  task t_reset;
    bus(1'b0, A_CTRL, 32'h0, rd);
    check(rd, CTRL_RST, "ctrl reset");
    bus(1'b0, 8'h3c, 32'h5, rd);
    check(rd, 32'h0, "unmapped");
    check(32'(alarm_o.operational), 32'h1, "oper idle");
    $display("t_reset done");
  endtask
  task t_port;
    bus(1'b1, A_CTRL, 32'h0000_0710, rd);
    bus(1'b1, A_THRESH, 32'h0000_0010, rd);
    port_oof_i <= 4'h3;
    port_err_rate_i <= {8'h00, 8'h00, 8'h20, 8'h11};
    wait_clk(4);
    check(32'(alarm_o.oof), 32'h1, "oof");
    check(32'(alarm_o.excessive_error_rate), 32'h1, "rate high");
    check(32'(alarm_o.operational), 32'h0, "oper alarm");
    port_err_rate_i[0] <= 8'h10;
    wait_clk(4);
    check(32'(alarm_o.excessive_error_rate), 32'h1, "rate equal");
    port_err_rate_i <= '0;
    port_oof_i <= 4'h0;
    wait_clk(4);
    check(32'(alarm_o[7:0]), 32'h0, "port clear");
    $display("t_port done");
  endtask
  task t_mgmt;
    mgmt_link_down_i <= 3'h5;
    wait_clk(4);
    check(32'(alarm_o.mgmt_down), 32'h1, "mgmt down");
    mgmt_link_down_i <= 3'h0;
    wait_clk(4);
    check(32'(alarm_o.mgmt_down), 32'h0, "mgmt up");
    $display("t_mgmt done");
  endtask
  task t_health;
    bus(1'b1, A_IRQ_MASK, 32'h1e, rd);
    selftest_result_i <= 16'h0042;
    selftest_done_i <= 1'b1;
    fault_evt_i <= 1'b1;
    internal_fault_code_i <= 32'h1234_abcd;
    download_abort_i <= 1'b1;
    wait_clk(1);
    selftest_done_i <= 1'b0;
    internal_fault_code_i <= 32'h0f0f_0f0f;
    download_abort_i <= 1'b0;
    wait_clk(1);
    fault_evt_i <= 1'b0;
    wait_clk(4);
    check(32'(alarm_o[13:11]), 32'h7, "health");
    bus(1'b0, A_SELFTEST, 32'h0, rd);
    check(rd, 32'h0042, "detail");
    bus(1'b0, A_FAULT, 32'h0, rd);
    check(rd, 32'h1234_abcd, "code");
    bus(1'b0, A_IRQ_STAT, 32'h0, rd);
    check(rd, 32'h16, "irq stat");
    check(32'(irq_o), 32'h1, "irq on");
    bus(1'b1, A_IRQ_MASK, 32'h0, rd);
    wait_clk(2);
    check(32'(irq_o), 32'h0, "irq masked");
    bus(1'b1, A_IRQ_MASK, 32'h1f, rd);
    bus(1'b1, A_IRQ_STAT, 32'h16, rd);
    wait_clk(2);
    check(32'(irq_o), 32'h0, "irq cleared");
    check(32'(alarm_o[13:12]), 32'h3, "latched");
    $display("t_health done");
  endtask
  task t_test;
    loop_active_i <= 4'h2;
    wait_clk(4);
    check(32'(alarm_o.test_active), 32'h1, "loop");
    loop_active_i <= 4'h0;
    pattern_active_i <= 1'b1;
    wait_clk(4);
    check(32'(alarm_o.test_active), 32'h1, "pattern");
    pattern_active_i <= 1'b0;
    mclk_lost_i <= 1'b1;
    wait_clk(4);
    check(32'(alarm_o[17:14]), 32'ha, "mclk");
    mclk_lost_i <= 1'b0;
    wait_clk(4);
    check(32'(alarm_o.timing_int), 32'h0, "mclk back");
    $display("t_test done");
  endtask
  task t_perf;
    int n;
    n = 0;
    line_on <= 1'b1;
    bus(1'b1, A_IRQ_STAT, 32'h1, rd);
    bus(1'b1, A_CTRL, 32'h0000_0713, rd);
    perf(1, 0, 6, 0, 32'h0, "valid start");
    do
      bus(1'b0, A_IRQ_STAT, 32'h0, rd);
    while (rd[IRQ_IVL] !== 1'b1 && n++ < 2000);
    check(32'(rd[IRQ_IVL]), 32'h1, "interval end");
    perf(1, 1, 0, 0, 32'd900, "user es");
    perf(1, 1, 4, 0, 32'd900, "user evt");
    perf(0, 1, 4, 0, 32'h0, "carrier evt");
    perf(0, 0, 6, 0, 32'h1, "carrier valid");
    perf(1, 0, 6, 0, 32'h1, "user valid");
    perf(1, 0, 0, 1, 32'd900, "user total");
    perf(1, 2, 0, 0, 32'h0, "past valid");
    perf(2, 0, 6, 0, 32'h1, "far valid");
    perf(3, 0, 6, 0, 32'h1, "near valid");
    perf(4, 0, 6, 0, 32'h0, "port off");
    bus(1'b1, A_CTRL, 32'h0000_0713, rd);
    perf(1, 0, 6, 0, 32'h0, "clr valid");
    perf(1, 0, 0, 1, 32'h0, "clr total");
    $display("t_perf done");
  endtask
  task results;
    $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_clk(2);
    t_reset();
    t_port();
    t_mgmt();
    t_health();
    t_test();
    t_perf();
    results();
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    results();
  end
endmodule
